// File: gpio_port.sv
// Purpose: sixteen-pin I/O port with per-pin PWM routing
// Assumes: pins and PWM inputs synchronous to clk (40 MHz)
// Notes:   read data appear in the cycle after the read strobe
//
// The strobed register port was decided locally.
module gpio_port
    import gpio_port_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire reg_req_s            req,
    output logic [DATA_W-1:0]        rdata,
    input  wire logic [NUM_PINS-1:0] io_in,
    output logic [NUM_PINS-1:0]      io_out,
    output logic [NUM_PINS-1:0]      io_oe,
    output logic [NUM_PINS-1:0]      sensor_en,
    input  wire logic [NUM_PWM-1:0]  pwm_wave,
    input  wire logic [NUM_PWM-1:0]  pwm_done,
    output logic                     irq
);

    logic [NUM_PINS-1:0] dir_reg;
    logic [NUM_PINS-1:0] level_reg;
    logic [NUM_PINS-1:0] func_reg;
    logic [NUM_PINS-1:0] flags_reg;
    logic [NUM_PINS-1:0] mask_reg;
    logic [NUM_PINS-1:0] prev_reg;
    logic                primed_reg;
    route_s              route_reg [NUM_PINS];
    logic [NUM_PINS-1:0] out_next;
    logic [NUM_PINS-1:0] oe_next;
    logic [NUM_PINS-1:0] change;
    logic [NUM_PINS-1:0] clr;
    logic [DATA_W-1:0]   rdata_next;
    logic [NUM_PINS-1:0] flags_next;
    logic [NUM_PINS-1:0] mask_next;

    // byte write into one half of a 16-bit pair
    function automatic logic [15:0] put_byte(input logic [15:0] old,
                                             input logic        hi,
                                             input logic [7:0]  b);
        put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction

    // single bit, set by a write hitting either byte of the pair that starts at lo
    function automatic logic hits(input reg_req_s r,
                                  input logic [7:0] lo);
        hits = r.wr && (r.addr[7:1] == lo[7:1]);
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_reg <= PAIR_RESET; // RQ13
        end else if (hits(req, DIR_LO)) begin
            dir_reg <= put_byte(dir_reg, req.addr[0], req.wdata); // RQ2 RQ1
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_reg <= PAIR_RESET; // RQ13
        end else if (hits(req, LEVEL_LO)) begin
            level_reg <= put_byte(level_reg, req.addr[0], req.wdata); // RQ4
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            func_reg <= PAIR_RESET; // RQ13
        end else if (hits(req, FUNC_LO)) begin
            func_reg <= put_byte(func_reg, req.addr[0], req.wdata); // RQ5
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_reg <= PAIR_RESET;
        end else if (hits(req, MASK_LO)) begin
            mask_reg <= put_byte(mask_reg, req.addr[0], req.wdata);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_route
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    route_reg[gi] <= route_s'(ROUTE_RESET); // RQ13
                end else if (req.wr && req.addr == ROUTE_BASE + 8'(gi)) begin
                    // spare bits are kept so they read back as written
                    route_reg[gi] <= route_s'(req.wdata); // RQ8 RQ11
                end
            end

            always_comb begin
                if (route_reg[gi].en) begin
                    oe_next[gi]  = 1'b1; // RQ9 RQ7
                    out_next[gi] = pwm_done[route_reg[gi].sel]
                                 ? route_reg[gi].idle // RQ10
                                 : pwm_wave[route_reg[gi].sel]; // RQ11
                end else if (func_reg[gi] && dir_reg[gi]) begin
                    oe_next[gi]  = 1'b1; // RQ2 RQ5
                    out_next[gi] = level_reg[gi]; // RQ4
                end else begin
                    oe_next[gi]  = 1'b0;
                    out_next[gi] = 1'b0;
                end
            end

            // only pins the logic does not drive report changes
            assign change[gi] = primed_reg && !dir_reg[gi]
                              && !route_reg[gi].en
                              && (io_in[gi] != prev_reg[gi]); // RQ12
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_oe     <= '0;
            io_out    <= '0;
            sensor_en <= '1;
        end else begin
            io_oe     <= oe_next;
            io_out    <= out_next;
            // sensor role only while neither I/O nor PWM owns the pin
            for (int i = 0; i < NUM_PINS; i++) begin
                sensor_en[i] <= !func_reg[i] && !route_reg[i].en; // RQ5
            end
        end
    end

    // first sample after reset only primes the history, no false flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_reg   <= '0;
            primed_reg <= 1'b0;
        end else begin
            prev_reg   <= io_in;
            primed_reg <= 1'b1;
        end
    end

    always_comb begin
        clr = '0;
        if (hits(req, FLAGS_LO)) begin
            clr = req.addr[0] ? {req.wdata, 8'h00} : {8'h00, req.wdata};
        end
    end

    // set wins over a clear in the same cycle
    always_comb begin
        flags_next = (flags_reg & ~clr) | change; // RQ12
    end

    // irq looks at next flags and mask, so it never lags a mask write
    always_comb begin
        mask_next = mask_reg;
        if (hits(req, MASK_LO)) begin
            mask_next = put_byte(mask_reg, req.addr[0], req.wdata);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_reg <= PAIR_RESET;
        end else begin
            flags_reg <= flags_next; // RQ12
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags_next & mask_next);
        end
    end

    always_comb begin
        rdata_next = UNMAPPED_RD;
        case (req.addr)
            FLAGS_LO: rdata_next = flags_reg[7:0];
            FLAGS_HI: rdata_next = flags_reg[15:8];
            MASK_LO:  rdata_next = mask_reg[7:0];
            MASK_HI:  rdata_next = mask_reg[15:8];
            DIR_LO:   rdata_next = dir_reg[7:0];
            DIR_HI:   rdata_next = dir_reg[15:8];
            MON_LO:   rdata_next = io_in[7:0]; // RQ3
            MON_HI:   rdata_next = io_in[15:8]; // RQ3
            LEVEL_LO: rdata_next = level_reg[7:0];
            LEVEL_HI: rdata_next = level_reg[15:8];
            FUNC_LO:  rdata_next = func_reg[7:0];
            FUNC_HI:  rdata_next = func_reg[15:8];
            default: begin
                if (req.addr >= ROUTE_BASE && req.addr <= ROUTE_LAST) begin
                    rdata_next = route_reg[req.addr[3:0]]; // RQ8
                end
            end
        endcase
    end

    // data only stand in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= req.rd ? rdata_next : UNMAPPED_RD;
        end
    end

    // checks on pins 0, 8 and 15 stand for every pin of the generate loop
    logic [2:0] sel0;
    logic [2:0] sel15;
    assign sel0  = route_reg[0].sel;
    assign sel15 = route_reg[15].sel;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    dir_readback_a: assert property ( // RQ2
        req.rd && req.addr == DIR_HI |=> rdata == $past(dir_reg[15:8]))
        else $error("direction high byte read back wrong");

    monitor_read_a: assert property ( // RQ3
        req.rd && req.addr == MON_LO |=> rdata == $past(io_in[7:0]))
        else $error("monitor did not return pin levels");

    level_drive_a: assert property ( // RQ4
        !route_reg[0].en && func_reg[0] && dir_reg[0]
        |=> io_oe[0] && io_out[0] == $past(level_reg[0]))
        else $error("output level not driven on pin 0");

    input_float_a: assert property ( // RQ5
        !route_reg[0].en && !(func_reg[0] && dir_reg[0]) |=> !io_oe[0])
        else $error("pin 0 driven while not an output");

    pwm_route_a: assert property ( // RQ9
        route_reg[0].en && !pwm_done[sel0]
        |=> io_oe[0] && io_out[0] == $past(pwm_wave[sel0]))
        else $error("routed pwm wave not on pin 0");

    idle_hold_a: assert property ( // RQ10
        route_reg[0].en && pwm_done[sel0]
        |=> io_out[0] == $past(route_reg[0].idle))
        else $error("idle level wrong after pwm sequence");

    change_flag_a: assert property ( // RQ12
        primed_reg && !dir_reg[0] && !route_reg[0].en
        && $changed(io_in[0]) |=> flags_reg[0])
        else $error("input change did not set flag");

    flag_clear_a: assert property ( // RQ12
        req.wr && req.addr == FLAGS_LO && req.wdata[0] && !change[0]
        |=> !flags_reg[0])
        else $error("write one did not clear flag");

    irq_level_a: assert property (
        irq == |(flags_reg & mask_reg))
        else $error("interrupt not equal to unmasked flags");

    route_write_a: assert property ( // RQ8
        req.wr && req.addr == ROUTE_BASE |=> route_reg[0] == $past(req.wdata))
        else $error("routing register 0 not written");

    route_readback_a: assert property ( // RQ8
        req.rd && req.addr == ROUTE_LAST |=> rdata == $past(route_reg[15]))
        else $error("routing register 15 read back wrong");

    route_spare_a: assert property ( // RQ11
        req.wr && req.addr == ROUTE_LAST
        |=> route_reg[15].spare == $past(req.wdata[6:4]))
        else $error("spare routing bits not stored");

    mon_hi_read_a: assert property ( // RQ3
        req.rd && req.addr == MON_HI |=> rdata == $past(io_in[15:8]))
        else $error("monitor high byte wrong");

    level_readback_a: assert property ( // RQ4
        req.rd && req.addr == LEVEL_LO |=> rdata == $past(level_reg[7:0]))
        else $error("output level low byte read back wrong");

    func_readback_a: assert property ( // RQ5
        req.rd && req.addr == FUNC_HI |=> rdata == $past(func_reg[15:8]))
        else $error("function high byte read back wrong");

    rdata_idle_a: assert property (
        !req.rd |=> rdata == UNMAPPED_RD)
        else $error("read data not idle outside a read");

    dir_write_a: assert property ( // RQ2
        req.wr && req.addr == DIR_LO |=> dir_reg[7:0] == $past(req.wdata))
        else $error("direction low byte not written");

    level_write_a: assert property ( // RQ4
        req.wr && req.addr == LEVEL_HI |=> level_reg[15:8] == $past(req.wdata))
        else $error("output level high byte not written");

    mask_write_a: assert property (
        req.wr && req.addr == MASK_HI |=> mask_reg[15:8] == $past(req.wdata))
        else $error("mask high byte not written");

    sensor_role_a: assert property ( // RQ5
        !func_reg[0] && !route_reg[0].en |=> sensor_en[0])
        else $error("pin 0 left its sensor role");

    sensor_off_a: assert property ( // RQ5
        func_reg[15] || route_reg[15].en |=> !sensor_en[15])
        else $error("pin 15 still in sensor role");

    level_drive_hi_a: assert property ( // RQ4
        !route_reg[15].en && func_reg[15] && dir_reg[15]
        |=> io_oe[15] && io_out[15] == $past(level_reg[15]))
        else $error("output level not driven on pin 15");

    input_float_hi_a: assert property ( // RQ2
        !route_reg[15].en && !(func_reg[15] && dir_reg[15]) |=> !io_oe[15])
        else $error("pin 15 driven while not an output");

    pwm_route_hi_a: assert property ( // RQ7
        route_reg[15].en && !pwm_done[sel15]
        |=> io_oe[15] && io_out[15] == $past(pwm_wave[sel15]))
        else $error("routed pwm wave not on pin 15");

    idle_hold_hi_a: assert property ( // RQ10
        route_reg[15].en && pwm_done[sel15]
        |=> io_oe[15] && io_out[15] == $past(route_reg[15].idle))
        else $error("idle level wrong on pin 15");

    change_flag_hi_a: assert property ( // RQ12
        primed_reg && !dir_reg[15] && !route_reg[15].en
        && $changed(io_in[15]) |=> flags_reg[15])
        else $error("input change did not set flag 15");

    flag_sticky_a: assert property ( // RQ12
        flags_reg[0] && !clr[0] |=> flags_reg[0])
        else $error("flag 0 dropped without a clear");

    flag_quiet_a: assert property ( // RQ12
        !change[0] && !flags_reg[0] |=> !flags_reg[0])
        else $error("flag 0 set with no input change");

    output_no_flag_a: assert property ( // RQ12
        dir_reg[8] && !flags_reg[8] |=> !flags_reg[8])
        else $error("driven pin 8 raised a change flag");

    routed_no_flag_a: assert property ( // RQ9
        route_reg[15].en && !flags_reg[15] |=> !flags_reg[15])
        else $error("routed pin 15 raised a change flag");

endmodule

// File: gpio_port_pkg.sv
// What this block does
// RQ1: sixteen channels, low byte 0-7, high 8-15
// RQ2: direction bit one makes pin an output
// RQ3: monitor register reads every pin's level
// RQ4: output level register sets driven level
// RQ5: function select one means general I/O
// RQ6: software should make unused channels outputs
// RQ7: any of eight PWM drives any pin
// RQ8: one 8-bit routing register per channel
// RQ9: routing bit 7 hands pin to PWM
// RQ10: finished sequence holds level from bit 3
// RQ11: bits 2-0 pick controller, 6-4 stored only
// RQ12: input level change sets write-one-clear flag
// RQ13: all control registers reset to zero
//
// Purpose: constants and types for the sixteen-pin I/O port
// Assumes: byte-wide register port, byte addresses as printed
// Notes:   each 16-bit register is an LSB/MSB byte pair
package gpio_port_pkg;

    localparam int unsigned NUM_PINS  = 16;
    localparam int unsigned NUM_PWM   = 8;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 8;

    localparam logic [7:0] FLAGS_LO   = 8'h0A;
    localparam logic [7:0] FLAGS_HI   = 8'h0B;
    localparam logic [7:0] MASK_LO    = 8'h0C;
    localparam logic [7:0] MASK_HI    = 8'h0D;
    localparam logic [7:0] DIR_LO     = 8'h10;
    localparam logic [7:0] DIR_HI     = 8'h11;
    localparam logic [7:0] MON_LO     = 8'h12;
    localparam logic [7:0] MON_HI     = 8'h13;
    localparam logic [7:0] LEVEL_LO   = 8'h14;
    localparam logic [7:0] LEVEL_HI   = 8'h15;
    localparam logic [7:0] FUNC_LO    = 8'h16;
    localparam logic [7:0] FUNC_HI    = 8'h17;
    localparam logic [7:0] ROUTE_BASE = 8'h20;
    localparam logic [7:0] ROUTE_LAST = 8'h2F;

    localparam logic [15:0] PAIR_RESET  = 16'h0000;
    localparam logic [7:0]  ROUTE_RESET = 8'h00;
    localparam logic [7:0]  UNMAPPED_RD = 8'h00;

    // routing byte: bit 7 enable, 6-4 spare, 3 idle level, 2-0 select
    typedef struct packed {
        logic       en;
        logic [2:0] spare;
        logic       idle;
        logic [2:0] sel;
    } route_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

endpackage

// File: gpio_port_tb.sv
// Purpose: self-checking bench for the I/O port and its PWM routing
// Assumes: byte register port, read data one cycle after the strobe
// Notes:   a second reset in mid-run primes the input-change history
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_total++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module gpio_port_with_pwm_routing_tb_top
    import gpio_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk;
    logic                rst;
    logic                irq;
    reg_req_s            req;
    logic [DATA_W-1:0]   rdata;
    logic [NUM_PINS-1:0] io_in;
    logic [NUM_PINS-1:0] io_out;
    logic [NUM_PINS-1:0] io_oe;
    logic [NUM_PINS-1:0] sensor_en;
    logic [NUM_PINS-1:0] ext_level;
    logic [NUM_PINS-1:0] ext_en;
    logic [NUM_PWM-1:0]  pwm_wave;
    logic [NUM_PWM-1:0]  pwm_done;
    int                  err_total;
    int                  check_count;
    int                  cyc;

    gpio_port i_dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .sensor_en(sensor_en), .pwm_wave(pwm_wave),
        .pwm_done(pwm_done), .irq(irq));
    pin_partner i_pins (.clk(clk), .io_out(io_out), .io_oe(io_oe),
        .ext_level(ext_level), .ext_en(ext_en), .io_in(io_in));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // a hang costs one error and ends the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            close_out();
        end
    end

    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle();
        settle();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        #1;
        `CHK("rdata", e, rdata)
    endtask

    task automatic pins(input logic [15:0] oe, input logic [15:0] out);
        `CHK("io_oe", oe, io_oe)
        `CHK("io_out", out, io_out)
    endtask

    task automatic t_reset;
        pins(16'h0000, 16'h0000);
        `CHK("sensor_en", 16'hFFFF, sensor_en)
        `CHK("irq", 1'b0, irq)
        // unmapped places among these read as zero
        for (int a = 8'h08; a <= 8'h2F; a++) rchk(8'(a), 8'h00);
    endtask

    task automatic t_gpio;
        ext_level <= 16'hA5C3;
        wr(DIR_LO, 8'hF0);
        wr(DIR_HI, 8'h0F);
        wr(LEVEL_LO, 8'h30);
        wr(LEVEL_HI, 8'h0C);
        wr(FUNC_LO, 8'hFF);
        wr(FUNC_HI, 8'hFF);
        wr(MON_LO, 8'h55);
        settle();
        pins(16'h0FF0, 16'h0C30);
        `CHK("sensor_en", 16'h0000, sensor_en)
        rchk(MON_LO, 8'h33);
        rchk(MON_HI, 8'hAC);
        rchk(DIR_HI, 8'h0F);
        rchk(LEVEL_HI, 8'h0C);
        rchk(FUNC_LO, 8'hFF);
        wr(FUNC_HI, 8'h00);
        settle();
        `CHK("io_oe", 16'h00F0, io_oe)
        `CHK("sensor_en", 16'hFF00, sensor_en)
    endtask

    task automatic t_route;
        @(posedge clk);
        pwm_wave <= 8'h96;
        for (int n = 0; n < 16; n++) wr(ROUTE_BASE + 8'(n), {4'hD, 4'(n)});
        settle();
        pins(16'hFFFF, 16'h9696);
        @(posedge clk);
        pwm_done <= 8'h0F;
        settle();
        pins(16'hFFFF, 16'h9F90);
        rchk(ROUTE_BASE + 8'h0B, 8'hDB);
        wr(ROUTE_BASE + 8'h03, 8'h00);
        settle();
        pins(16'hFFF7, 16'h9F90);
    endtask

    task automatic t_irq;
        ext_level <= 16'h0000;
        do_reset();
        rchk(ROUTE_BASE + 8'h0B, 8'h00);
        wr(MASK_LO, 8'h01);
        @(posedge clk);
        ext_level <= 16'h0103;
        settle();
        `CHK("irq", 1'b1, irq)
        rchk(FLAGS_LO, 8'h03);
        rchk(FLAGS_HI, 8'h01);
        wr(FLAGS_LO, 8'h00);
        rchk(FLAGS_LO, 8'h03);
        wr(FLAGS_LO, 8'h01);
        settle();
        `CHK("irq", 1'b0, irq)
        rchk(FLAGS_LO, 8'h02);
        wr(MASK_LO, 8'h02);
        settle();
        `CHK("irq", 1'b1, irq)
        wr(FLAGS_LO, 8'h02);
        wr(FLAGS_HI, 8'h01);
        // pin 8 now driven low against the outside: not an input change
        wr(DIR_HI, 8'h01);
        wr(FUNC_HI, 8'h01);
        settle();
        settle();
        rchk(FLAGS_HI, 8'h00);
        `CHK("irq", 1'b0, irq)
        // pin 2 left floating toggles, which must raise its flag
        @(posedge clk);
        ext_en <= 16'hFFFB;
        settle();
        settle();
        rchk(FLAGS_LO, 8'h04);
        `CHK("irq", 1'b0, irq)
    endtask

    initial begin
        req = '0;
        rst = 1'b1;
        pwm_wave = 8'h00;
        pwm_done = 8'h00;
        ext_level = 16'h0000;
        ext_en = 16'hFFFF;
        err_total = 0;
        check_count = 0;
        cyc = 0;
        do_reset();
        t_reset();
        t_gpio();
        t_route();
        t_irq();
        close_out();
    end
endmodule

// File: pin_partner.sv
// Purpose: far-side circuitry on the sixteen shared pins
// Assumes: the pin settles in the cycle in which the device drives it
// Notes:   no pull on the pins, so a pin nobody drives flips each cycle
module pin_partner
    import gpio_port_pkg::*;
(
    input  wire logic                clk,
    input  wire logic [NUM_PINS-1:0] io_out,
    input  wire logic [NUM_PINS-1:0] io_oe,
    input  wire logic [NUM_PINS-1:0] ext_level,
    input  wire logic [NUM_PINS-1:0] ext_en,
    output logic [NUM_PINS-1:0]      io_in
);
    logic [NUM_PINS-1:0] last_reg;

    // a floating pin must never look like a held level
    assign io_in = (io_oe & io_out) | (~io_oe & ext_en & ext_level)
                 | (~io_oe & ~ext_en & ~last_reg);

    always_ff @(posedge clk) begin
        last_reg <= io_in;
    end
endmodule
